// *** hw/mssm_top.sv ***
// Motor start and stall monitor: detection, timing and outputs behind an APB slave.
//
// Implementation choices: the placing of the registers and the APB slave port.
`default_nettype none
module mssm_top #(
  parameter int TICK_CYCLES = mssm_pkg::TICK_CYCLES,
  parameter int DETECT_CYCLES = mssm_pkg::DETECT_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements from same-clock logic
  input wire logic [11:0] phase_current,
  input wire logic [9:0] theta_used,
  // Pins
  input wire logic speed_contact,
  input wire logic block_in,
  // Protection outputs
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic overcurrent,
  output logic stall_tc,
  output logic hot_curve,
  output logic speed_fail
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_START,
    ST_RUN,
    ST_STALL,
    ST_TRIP
  } mssm_state_t;

  mssm_pkg::mssm_cfg_t cfg;
  mssm_pkg::mssm_stat_t stat;
  mssm_state_t state;
  mssm_state_t next_state;
  logic [1:0] speed_sync;
  logic [1:0] block_sync;
  logic [31:0] tick_cnt;
  logic [31:0] win_cnt;
  logic tick;
  logic [18:0] elapsed;
  logic [47:0] heat_acc;
  logic speed_seen;
  logic [12:0] sel_time;
  logic hot_sel;

  // Register file
  mssm_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg),
    .stat(stat)
  );

  // Stall curve selection
  mssm_stall_sel u_sel (
    .pclk(pclk),
    .presetn(presetn),
    .stall_cold(cfg.stall_cold),
    .stall_hot(cfg.stall_hot),
    .hot_theta(cfg.hot_theta),
    .theta(theta_used),
    .sel_time(sel_time),
    .hot_curve(hot_sel)
  );

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_sync <= 2'h0;
      block_sync <= 2'h0;
    end else begin
      speed_sync <= {speed_sync[0], speed_contact};
      block_sync <= {block_sync[0], block_in};
    end
  end

  // Speed contact level after polarity: NC contacts signal by opening
  wire speed_active = speed_sync[1] ^ cfg.speed_contact_polarity;
  wire blocked = block_sync[1];

  // Program cycle divider; start and speed times count in these ticks, stall times in 0.1 s steps of them
  wire tick_wrap = tick_cnt == 32'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? 32'h0 : tick_cnt + 32'h1;
      tick <= tick_wrap;
    end
  end

  // Current comparisons against the settings
  wire above_noload = phase_current > cfg.noload;
  wire above_detect = phase_current > cfg.start_detect;
  wire above_ovl = phase_current > cfg.ovl_max;
  wire above_lr = phase_current > cfg.lr_max;
  wire soft_start = cfg.start_mode == mssm_pkg::START_SOFT;
  wire win_over = win_cnt >= 32'(DETECT_CYCLES);

  // Heating limit: Ilr squared times selected stall time in program cycles
  wire [23:0] cur_sq = 24'(phase_current) * 24'(phase_current);
  wire [23:0] lr_sq = 24'(cfg.lr_nom) * 24'(cfg.lr_nom);
  wire [17:0] stall_ticks = 18'(sel_time) * mssm_pkg::STALL_STEP_TICKS;
  wire [47:0] heat_limit = 48'(lr_sq) * 48'(stall_ticks);

  // Trip decisions for an active timing
  wire timing = (state == ST_START) || (state == ST_STALL);
  wire def_up = elapsed >= cfg.start_time;
  wire heat_up = heat_acc > heat_limit;
  wire time_up = cfg.heat_integral_mode ? heat_up : def_up;
  wire speed_miss = (state == ST_START) && cfg.speed_use && !speed_seen
    && (elapsed >= cfg.speed_contact_timeout);
  wire trip_cond = timing && !blocked && (time_up || speed_miss);
  wire start_cond = timing && !blocked;
  wire block_cond = timing && blocked;

  // Start declaration: fast rise for line starts, plain detect for soft starts
  wire start_now = soft_start ? above_detect : (above_noload && above_detect);

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_now) begin
          next_state = ST_START;
        end else if (above_noload && !soft_start) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // A rise slower than the window is running current, not a start
        if (!above_noload) begin
          next_state = ST_IDLE;
        end else if (above_detect && !win_over) begin
          next_state = ST_START;
        end else if (win_over) begin
          next_state = ST_RUN;
        end
      end
      ST_START: begin
        if (trip_cond) begin
          next_state = ST_TRIP;
        end else if (!above_ovl) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!above_noload) begin
          next_state = ST_IDLE;
        end else if (cfg.stall_mode && above_ovl) begin
          next_state = ST_STALL;
        end
      end
      ST_STALL: begin
        if (trip_cond) begin
          next_state = ST_TRIP;
        end else if (!above_ovl) begin
          next_state = ST_RUN;
        end
      end
      ST_TRIP: begin
        // Trip holds until the motor is disconnected
        if (!above_noload) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Rise window timer, restarted on each entry into the armed state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt <= 32'h0;
    end else if (state != ST_ARMED) begin
      win_cnt <= 32'h1;
    end else if (!win_over) begin
      win_cnt <= win_cnt + 32'h1;
    end
  end

  // Duration and heat counters; a block freezes them rather than clearing
  wire enter_timing = timing == 1'b0
    && (next_state == ST_START || next_state == ST_STALL);
  wire count_now = timing && !blocked && tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed <= 19'h0;
      heat_acc <= 48'h0;
    end else if (enter_timing) begin
      elapsed <= 19'h0;
      heat_acc <= 48'h0;
    end else if (count_now) begin
      elapsed <= (elapsed == 19'h7ffff) ? elapsed : elapsed + 19'h1;
      heat_acc <= heat_acc + 48'(cur_sq);
    end
  end

  // Speed contact seen during the current start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_seen <= 1'b0;
    end else if (state != ST_START) begin
      speed_seen <= 1'b0;
    end else if (speed_active) begin
      speed_seen <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
      overcurrent <= 1'b0;
      stall_tc <= 1'b0;
      hot_curve <= 1'b0;
    end else begin
      start_out <= start_cond && !trip_cond;
      trip_out <= next_state == ST_TRIP;
      blocked_out <= block_cond;
      overcurrent <= above_lr;
      stall_tc <= above_ovl;
      hot_curve <= hot_sel;
    end
  end

  // Halted start flag lasts until the trip is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_fail <= 1'b0;
    end else if (trip_cond && speed_miss) begin
      speed_fail <= 1'b1;
    end else if (next_state == ST_IDLE) begin
      speed_fail <= 1'b0;
    end
  end

  // State seen by software
  assign stat = '{start_out, trip_out, blocked_out, overcurrent, stall_tc,
    hot_curve, speed_fail, state, elapsed};
endmodule
`default_nettype wire

// *** common/mssm_pkg.sv ***
// Package of constants and carrier types for the motor start and stall monitor.
`default_nettype none
package mssm_pkg;
  // Clock and program cycle timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PROG_CYCLE_US = 5000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * PROG_CYCLE_US;
  localparam int DETECT_WINDOW_US = 10000;
  localparam int DETECT_CYCLES = CLK_HZ / 1_000_000 * DETECT_WINDOW_US;
  // Program cycles in one 0.1 s stall time step
  localparam int STALL_STEP_US = 100000;
  localparam logic [17:0] STALL_STEP_TICKS = 18'(STALL_STEP_US / PROG_CYCLE_US);
  localparam logic [9:0] THETA_FULL = 10'h3e8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CUR_LIMIT = 8'h04;
  localparam logic [7:0] OFF_START_LIMIT = 8'h08;
  localparam logic [7:0] OFF_THERMAL = 8'h0c;
  localparam logic [7:0] OFF_STALL_TIME = 8'h10;
  localparam logic [7:0] OFF_START_TIME = 8'h14;
  localparam logic [7:0] OFF_SPEED_WAIT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_ELAPSED = 8'h20;

  // Start mode codes
  localparam logic [1:0] START_DIRECT_LINE = 2'h0;
  localparam logic [1:0] START_STAR_DELTA = 2'h1;
  localparam logic [1:0] START_SOFT = 2'h2;

  // Reset values: currents in 0.1 xIn, theta in 0.1 %, stall in 0.1 s, times in 5 ms
  localparam logic [11:0] RST_LR_MAX = 12'h04b;
  localparam logic [11:0] RST_OVL_MAX = 12'h014;
  localparam logic [11:0] RST_START_DETECT = 12'h00f;
  localparam logic [11:0] RST_NOLOAD = 12'h002;
  localparam logic [11:0] RST_LR_NOM = 12'h03c;
  localparam logic [9:0] RST_HOT_THETA = 10'h2bc;
  localparam logic [12:0] RST_STALL_COLD = 13'h00c8;
  localparam logic [12:0] RST_STALL_HOT = 13'h0096;
  localparam logic [18:0] RST_START_TIME = 19'h00008;
  localparam logic [18:0] RST_SPEED_WAIT = 19'h00008;

  // Settings carried from the register file to the monitor
  typedef struct packed {
    logic heat_integral_mode;
    logic speed_use;
    logic speed_contact_polarity;
    logic stall_mode;
    logic [1:0] start_mode;
    logic [11:0] lr_max;
    logic [11:0] ovl_max;
    logic [11:0] start_detect;
    logic [11:0] noload;
    logic [11:0] lr_nom;
    logic [9:0] hot_theta;
    logic [12:0] stall_cold;
    logic [12:0] stall_hot;
    logic [18:0] start_time;
    logic [18:0] speed_contact_timeout;
  } mssm_cfg_t;

  // Monitor state shown to software
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
    logic overcurrent;
    logic stall_tc;
    logic hot_curve;
    logic speed_fail;
    logic [2:0] state;
    logic [18:0] elapsed;
  } mssm_stat_t;
endpackage
`default_nettype wire

// *** hw/mssm_apb_regs.sv ***
// APB register file holding the monitor settings and reading back its state.
`default_nettype none
module mssm_apb_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block side
  output mssm_pkg::mssm_cfg_t cfg,
  input wire mssm_pkg::mssm_stat_t stat
);
  // Unaligned or unlisted offsets do not hit
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a <= mssm_pkg::OFF_ELAPSED);
  endfunction

  wire access = psel & penable & ~pready;
  wire hit = addr_hit(paddr);
  wire wr_en = psel & penable & pready & pwrite & addr_hit(paddr);
  logic [31:0] rd_val;

  // Read mux; reserved bits read as zero
  always_comb begin
    rd_val = 32'h0;
    unique case (paddr)
      mssm_pkg::OFF_CTRL: rd_val = {26'h0, cfg.start_mode, cfg.stall_mode,
        cfg.speed_contact_polarity, cfg.speed_use, cfg.heat_integral_mode};
      mssm_pkg::OFF_CUR_LIMIT: rd_val = {4'h0, cfg.ovl_max, 4'h0, cfg.lr_max};
      mssm_pkg::OFF_START_LIMIT: rd_val = {4'h0, cfg.noload, 4'h0, cfg.start_detect};
      mssm_pkg::OFF_THERMAL: rd_val = {4'h0, cfg.lr_nom, 6'h0, cfg.hot_theta};
      mssm_pkg::OFF_STALL_TIME: rd_val = {3'h0, cfg.stall_hot, 3'h0, cfg.stall_cold};
      mssm_pkg::OFF_START_TIME: rd_val = {13'h0, cfg.start_time};
      mssm_pkg::OFF_SPEED_WAIT: rd_val = {13'h0, cfg.speed_contact_timeout};
      mssm_pkg::OFF_STATUS: rd_val = {22'h0, stat.state, stat.speed_fail, stat.hot_curve,
        stat.stall_tc, stat.overcurrent, stat.blocked, stat.trip, stat.start};
      mssm_pkg::OFF_ELAPSED: rd_val = {13'h0, stat.elapsed};
      default: rd_val = 32'h0;
    endcase
  end

  // One wait state, then answer with data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      prdata <= (access & ~pwrite) ? rd_val : 32'h0;
      pslverr <= access & ~hit;
    end
  end

  // Setting writes take effect at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{1'b0, 1'b0, 1'b0, 1'b0, mssm_pkg::START_DIRECT_LINE,
        mssm_pkg::RST_LR_MAX, mssm_pkg::RST_OVL_MAX, mssm_pkg::RST_START_DETECT,
        mssm_pkg::RST_NOLOAD, mssm_pkg::RST_LR_NOM, mssm_pkg::RST_HOT_THETA,
        mssm_pkg::RST_STALL_COLD, mssm_pkg::RST_STALL_HOT, mssm_pkg::RST_START_TIME,
        mssm_pkg::RST_SPEED_WAIT};
    end else if (wr_en) begin
      unique case (paddr)
        mssm_pkg::OFF_CTRL: begin
          cfg.heat_integral_mode <= pwdata[0];
          cfg.speed_use <= pwdata[1];
          cfg.speed_contact_polarity <= pwdata[2];
          cfg.stall_mode <= pwdata[3];
          cfg.start_mode <= pwdata[5:4];
        end
        mssm_pkg::OFF_CUR_LIMIT: begin
          cfg.lr_max <= pwdata[11:0];
          cfg.ovl_max <= pwdata[27:16];
        end
        mssm_pkg::OFF_START_LIMIT: begin
          cfg.start_detect <= pwdata[11:0];
          cfg.noload <= pwdata[27:16];
        end
        mssm_pkg::OFF_THERMAL: begin
          cfg.hot_theta <= pwdata[9:0];
          cfg.lr_nom <= pwdata[27:16];
        end
        mssm_pkg::OFF_STALL_TIME: begin
          cfg.stall_cold <= pwdata[12:0];
          cfg.stall_hot <= pwdata[28:16];
        end
        mssm_pkg::OFF_START_TIME: cfg.start_time <= pwdata[18:0];
        mssm_pkg::OFF_SPEED_WAIT: cfg.speed_contact_timeout <= pwdata[18:0];
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hw/mssm_stall_sel.sv ***
// Safe stall time selection between hot and capacity-scaled cold curves.
`default_nettype none
module mssm_stall_sel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings and thermal state
  input wire logic [12:0] stall_cold,
  input wire logic [12:0] stall_hot,
  input wire logic [9:0] hot_theta,
  input wire logic [9:0] theta,
  // Selected time in 0.1 s and curve flag
  output logic [12:0] sel_time,
  output logic hot_curve
);
  // An unset cold time falls back to the hot one
  wire [12:0] cold_eff = (stall_cold == 13'h0) ? stall_hot : stall_cold;
  wire is_hot = theta > hot_theta;
  wire [9:0] theta_c = (theta > mssm_pkg::THETA_FULL) ? mssm_pkg::THETA_FULL : theta;
  wire [9:0] margin = mssm_pkg::THETA_FULL - theta_c;
  wire [22:0] prod = 23'(cold_eff) * 23'(margin);
  wire [22:0] quot = prod / 23'(mssm_pkg::THETA_FULL);
  // Never select zero, so a hot-less cold curve still times out
  wire [12:0] cold_scaled = (quot[12:0] == 13'h0) ? 13'h1 : quot[12:0];

  // Registered to keep the divider off the trip path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_time <= mssm_pkg::RST_STALL_HOT;
      hot_curve <= 1'b0;
    end else begin
      sel_time <= is_hot ? stall_hot : cold_scaled;
      hot_curve <= is_hot;
    end
  end
endmodule
`default_nettype wire

// *** tb/mssm_motor_model.sv ***
// Behavioural motor: phase current and speed contact seen by the monitor.
`default_nettype none
module mssm_motor_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic [11:0] level,
  input wire logic slow,
  input wire logic spin,
  input wire logic nc,
  // Measurement and contact
  output logic [11:0] phase_current,
  output logic speed_contact
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pace;
  // Slow mode climbs one step every fourth cycle, too slow to count as a start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_current <= 12'h000;
      pace <= 2'h0;
    end else begin
      pace <= pace + 2'h1;
      if (!slow || phase_current > level) begin
        phase_current <= level;
      end else if (pace == 2'h3 && phase_current < level) begin
        phase_current <= phase_current + 12'h001;
      end
    end
  end
  // Make contact reads high; a break contact opens once the rotor turns
  assign speed_contact = spin ^ nc;
endmodule
`default_nettype wire

// *** tb/mssm_top_chk.sv ***
// Port checker of the motor start and stall monitor, bound to its top.
`default_nettype none
module mssm_top_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus side
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Measurements and outputs
  input wire logic [11:0] phase_current,
  input wire logic [9:0] theta_used,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire logic overcurrent,
  input wire logic stall_tc,
  input wire logic hot_curve
);
  timeunit 1ns;
  timeprecision 1ns;
  // Limits are the reset ones, which the bench never rewrites
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_first_s;
    psel && penable && !pready;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  apb_wait_a: assert property (acc_first_s |=> answer_s)
    else $error("apb answer not one wait state");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero");
  oc_level_a: assert property (overcurrent == ($past(phase_current) > 12'h04b))
    else $error("overcurrent wrong");
  stall_tc_a: assert property (stall_tc == ($past(phase_current) > 12'h014))
    else $error("stall_tc wrong");
  hot_curve_a: assert property (hot_curve == ($past(theta_used, 2) > 10'h2bc))
    else $error("hot_curve wrong");
  start_excl_a: assert property (start_out |-> !trip_out && !blocked_out)
    else $error("start with trip or block");
  trip_hold_a: assert property (trip_out && phase_current > 12'h002 |=> trip_out)
    else $error("trip dropped early");
endmodule
bind mssm_top mssm_top_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .phase_current(phase_current),
  .theta_used(theta_used), .start_out(start_out), .trip_out(trip_out),
  .blocked_out(blocked_out), .overcurrent(overcurrent), .stall_tc(stall_tc),
  .hot_curve(hot_curve)
);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the motor start and stall monitor.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] phase_current, level;
  logic [9:0] theta_used;
  logic speed_contact, block_in, spin, nc, slow;
  logic start_out, trip_out, blocked_out, overcurrent, stall_tc, hot_curve, speed_fail;
  int n_fail, n_compared, cyc, n;
  // Rows: current, used capacity, then overcurrent, stall_tc, hot_curve
  logic [24:0] rows [5] = '{{12'h04b, 10'h2bc, 3'b010}, {12'h04c, 10'h2bd, 3'b111},
    {12'h014, 10'h000, 3'b000}, {12'h015, 10'h3e8, 3'b011}, {12'h000, 10'h000, 3'b000}};
  logic [31:0] rst_exp [7] = '{32'h0, 32'h0014004b, 32'h0002000f, 32'h003c02bc,
    32'h009600c8, 32'h8, 32'h8};
  // Short tick and window keep a definite-time start at the reset start time under a hundred cycles
  mssm_top #(.TICK_CYCLES(10), .DETECT_CYCLES(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_current(phase_current), .theta_used(theta_used), .speed_contact(speed_contact),
    .block_in(block_in), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .overcurrent(overcurrent), .stall_tc(stall_tc),
    .hot_curve(hot_curve), .speed_fail(speed_fail));
  mssm_motor_model motor_u (.pclk(pclk), .presetn(presetn), .level(level), .slow(slow),
    .spin(spin), .nc(nc), .phase_current(phase_current), .speed_contact(speed_contact));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard, far above the fewer than two thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request holds until the rising edge that samples pready high; data taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drive(input logic [11:0] lv, input int w);
    @(posedge pclk);
    level <= lv;
    repeat (w) @(negedge pclk);
  endtask
  task automatic wait_trip(input int lim);
    n = 0;
    while (trip_out !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
  endtask
  initial begin
    {psel, penable, pwrite, block_in, spin, nc, slow, presetn} = 8'h00;
    {paddr, pwdata, level, theta_used} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      level <= rows[i][24:13];
      theta_used <= rows[i][12:3];
      repeat (4) @(negedge pclk);
      check(32'({overcurrent, stall_tc, hot_curve}), 32'(rows[i][2:0]));
    end
    drive(12'h000, 20);
    $display("table done");
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, rst_exp[i]);
    end
    apb(1'b1, 8'h24, 32'h5);
    check(32'(err), 32'h1);
    $display("registers done");
    drive(12'h028, 6);
    check(32'(start_out), 32'h1);
    wait_trip(200);
    check(32'(n >= 60 && n <= 100), 32'h1);
    check(32'(start_out), 32'h0);
    drive(12'h000, 10);
    check(32'(trip_out), 32'h0);
    $display("definite done");
    block_in <= 1'b1;
    drive(12'h028, 10);
    check(32'({blocked_out, start_out}), 32'h2);
    repeat (150) @(negedge pclk);
    check(32'(trip_out), 32'h0);
    drive(12'h000, 20);
    block_in <= 1'b0;
    slow <= 1'b1;
    drive(12'h028, 300);
    check(32'({start_out, trip_out}), 32'h0);
    drive(12'h000, 20);
    slow <= 1'b0;
    $display("block and slow done");
    apb(1'b1, 8'h14, 32'd1000);
    apb(1'b1, 8'h00, 32'h2);
    drive(12'h028, 0);
    wait_trip(200);
    check(32'(n >= 60 && n <= 100), 32'h1);
    check(32'(speed_fail), 32'h1);
    drive(12'h000, 20);
    apb(1'b1, 8'h00, 32'h6);
    nc <= 1'b1;
    spin <= 1'b1;
    drive(12'h028, 200);
    check(32'({start_out, trip_out}), 32'h2);
    drive(12'h000, 20);
    apb(1'b1, 8'h00, 32'h0);
    {nc, spin} <= 2'b00;
    drive(12'h028, 200);
    check(32'(trip_out), 32'h0);
    drive(12'h000, 20);
    $display("speed contact done");
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h10, 32'h00020000);
    drive(12'h03c, 0);
    wait_trip(700);
    check(32'(n >= 380 && n <= 450), 32'h1);
    drive(12'h000, 20);
    $display("heat integral done");
    // Stall supervision: start ends, then an overload in run times out again
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h14, 32'h8);
    drive(12'h028, 10);
    drive(12'h010, 10);
    check(32'({start_out, trip_out}), 32'h0);
    drive(12'h028, 0);
    wait_trip(200);
    check(32'(n >= 60 && n <= 100), 32'h1);
    drive(12'h000, 20);
    $display("stall done");
    stop_test();
  end
endmodule
`default_nettype wire
